// file: pkg/timekeeping_regs.svh
/*
 * Register offsets, bit positions, reset values and timing constants
 * of the timekeeping page.
 * Assumes the byte-wide memory access port of the serial command logic.
 */
`ifndef TIMEKEEPING_REGS_SVH
`define TIMEKEEPING_REGS_SVH

// ==========================================================
// Page placement
`define TK_PAGE_NUM 11'h010
`define TK_DATA_PAGES 16
`define TK_PAGE_BYTES 30
`define TK_OFF_LAST 5'h1d

// ==========================================================
// Byte offsets within the page
`define TK_OFF_STATUS 5'h00
`define TK_OFF_CONTROL 5'h01
`define TK_OFF_RTC 5'h02
`define TK_OFF_ITV 5'h07
`define TK_OFF_CYC 5'h0c
`define TK_OFF_RTC_ALM 5'h10
`define TK_OFF_ITV_ALM 5'h15
`define TK_OFF_CYC_ALM 5'h1a
`define TK_LEN5 5'h05
`define TK_LEN4 5'h04

// ==========================================================
// Status bits
`define ST_RTC_FLAG 0
`define ST_ITV_FLAG 1
`define ST_CYC_FLAG 2
`define ST_IEN_LSB 3
`define ST_IEN_RESET 3'h7

// ==========================================================
// Control bits
`define CT_WP_LSB 0
`define CT_RO 3
`define CT_OSC 4
`define CT_AUTO 5
`define CT_STOP 6
`define CT_LINE_FILTER_DELAY_SEL 7
`define CT_RESET 8'h00

// ==========================================================
// Timing
`define MCLK_HZ 200000000
`define XTAL_HZ 32768
`define TICKS_PER_SEC 256
`define XTAL_PER_TICK (`XTAL_HZ / `TICKS_PER_SEC)
`define LONG_DELAY_US 123000
`define SHORT_DELAY_US 3500
`define US_PER_SEC 1000000
`define LONG_DELAY_XT ((64'(`LONG_DELAY_US) * `XTAL_HZ) / `US_PER_SEC)
`define SHORT_DELAY_XT ((`SHORT_DELAY_US * `XTAL_HZ) / `US_PER_SEC)
`define UNMAPPED_READ 8'hff

`endif

// file: pkg/timekeeping_pkg.sv
/*
 * Types shared by the timekeeping counters.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package timekeeping_pkg;

    typedef logic [39:0] count40_t;
    typedef logic [31:0] count32_t;

    typedef enum logic [1:0] {
        EXP_NONE = 2'b00,
        EXP_READ_ONLY = 2'b01,
        EXP_ID_ONLY = 2'b10
    } expire_t;

endpackage : timekeeping_pkg

// file: verilog/line_level_filter.sv
/*
 * Level filter for the single-wire I/O line.
 * Assumes the line is synchronous to mclk and a one-cycle crystal tick.
 */
`include "timekeeping_regs.svh"

module line_level_filter #(
    parameter int CNT_W = 13
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Time base and select
    input wire logic xtal_tick,
    input wire logic long_sel,
    // Line
    input wire logic line_in,
    // Filtered result
    output logic level,
    output logic fall
);

    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] limit;

    assign limit = long_sel ? CNT_W'(`LONG_DELAY_XT) : CNT_W'(`SHORT_DELAY_XT);

    // ======================================================
    // Persistence counter
    always_ff @(posedge mclk) begin
        if (srst || line_in == level) begin
            hold_cnt <= '0;
        end else if (xtal_tick) begin
            hold_cnt <= hold_cnt + 1'b1;
        end
    end

    // ======================================================
    // Accepted level and falling event
    always_ff @(posedge mclk) begin
        if (srst) begin
            level <= 1'b0;
            fall <= 1'b0;
        end else if (line_in != level && xtal_tick && hold_cnt + 1'b1 >= limit) begin
            level <= line_in;
            fall <= ~line_in;
        end else begin
            fall <= 1'b0;
        end
    end

endmodule : line_level_filter

// file: verilog/timekeeping_counters_alarms.sv
/*
 * Timekeeping page: seconds clock, interval timer, cycle counter,
 * alarms, protection and expiration, with snapshot holding registers.
 * Assumes a byte-wide memory access port from the serial command logic
 * and a one-cycle pulse at the eighth bit of a read-memory command.
 */
`include "timekeeping_regs.svh"

// What this block does
// - Oscillator control bit runs or halts time base
// - Counters and square wave hold while stopped
// - Snapshot counters at eighth read-command bit
// - Clock: five bytes, 256 counts per second
// - Interval timer: five bytes, 256 per second
// - Auto mode follows filtered I/O level
// - Mode bit selects automatic or manual gating
// - Manual: start/stop zero counts, one holds
// - Delay bit selects long or short filter
// - Cycle count increments on filtered falling edge
// - Counter equal alarm sets its flag
// - Active-low enables gate flags onto interrupt
// - Write protect locks counter, alarm, control
// - Protected alarm expires: read-only or ID-only
// - Status and control are first two bytes
// - Page after sixteen data pages, thirty bytes
module timekeeping_counters_alarms #(
    parameter int OSC_DIV = `MCLK_HZ / `XTAL_HZ,
    parameter int FILT_W = 13
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Memory access port
    input wire logic [15:0] mem_addr,
    input wire logic mem_wr_en,
    input wire logic [7:0] mem_wr_data,
    input wire logic wp_arm,
    input wire logic mem_rd_en,
    output logic [7:0] mem_rd_data,
    output logic mem_rd_valid,
    input wire logic read_cmd_bit8,
    // Single-wire I/O line
    input wire logic io_line,
    // Open-drain outputs
    output logic irq_out,
    output logic irq_oe,
    output logic seconds_square_out,
    output logic seconds_square_oe,
    // Expiration state
    output logic device_read_only,
    output logic device_id_only
);

    // ======================================================
    // Helper functions
    function automatic logic in_field(input logic [4:0] off, input logic [4:0] base,
                                      input logic [4:0] len);
        in_field = (off >= base) && (off < base + len);
    endfunction : in_field

    function automatic logic [39:0] set_byte(input logic [39:0] v, input logic [2:0] i,
                                             input logic [7:0] b);
        logic [39:0] r;
        r = v;
        r[i*8 +: 8] = b;
        set_byte = r;
    endfunction : set_byte

    function automatic logic [7:0] get_byte(input logic [39:0] v, input logic [2:0] i);
        get_byte = v[i*8 +: 8];
    endfunction : get_byte

    // ======================================================
    // Declarations
    logic [31:0] osc_cnt;
    logic xtal_tick;
    logic [6:0] prescale;
    logic tick256;
    logic [7:0] control;
    logic [2:0] wp;
    logic [2:0] ien_n;
    logic [2:0] flags;
    logic [2:0] hit;
    timekeeping_pkg::count40_t rtc;
    timekeeping_pkg::count40_t itv;
    timekeeping_pkg::count32_t cyc;
    timekeeping_pkg::count40_t rtc_alm;
    timekeeping_pkg::count40_t itv_alm;
    timekeeping_pkg::count32_t cyc_alm;
    timekeeping_pkg::count40_t rtc_hold;
    timekeeping_pkg::count40_t itv_hold;
    timekeeping_pkg::count32_t cyc_hold;
    timekeeping_pkg::expire_t expire;
    timekeeping_pkg::expire_t next_expire;
    logic [4:0] off;
    logic page_hit;
    logic wr_ok;
    logic wr;
    logic rd;
    logic io_level;
    logic io_fall;
    logic itv_run;
    logic [7:0] next_rd_data;

    // ======================================================
    // Address decode
    assign off = mem_addr[4:0];
    assign page_hit = (mem_addr[15:5] == `TK_PAGE_NUM) && (off <= `TK_OFF_LAST);
    assign wr_ok = (expire == timekeeping_pkg::EXP_NONE);
    assign wr = mem_wr_en && page_hit && wr_ok;
    assign rd = mem_rd_en && page_hit;

    // ======================================================
    // Crystal time base
    always_ff @(posedge mclk) begin
        if (srst || !control[`CT_OSC]) begin
            osc_cnt <= '0;
            xtal_tick <= 1'b0;
        end else if (osc_cnt == 32'(OSC_DIV - 1)) begin
            osc_cnt <= '0;
            xtal_tick <= 1'b1;
        end else begin
            osc_cnt <= osc_cnt + 32'h0000_0001;
            xtal_tick <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            prescale <= '0;
        end else if (xtal_tick) begin
            prescale <= prescale + 7'h01;
        end
    end

    assign tick256 = xtal_tick && (prescale == 7'(`XTAL_PER_TICK - 1));

    // ======================================================
    // I/O line filter
    line_level_filter #(
        .CNT_W(FILT_W)
    ) u_filter (
        .mclk(mclk),
        .srst(srst),
        .xtal_tick(xtal_tick),
        .long_sel(control[`CT_LINE_FILTER_DELAY_SEL]),
        .line_in(io_line),
        .level(io_level),
        .fall(io_fall)
    );

    // Interval gating
    assign itv_run = control[`CT_AUTO] ? io_level : ~control[`CT_STOP];

    // ======================================================
    // Control and write protect
    always_ff @(posedge mclk) begin
        if (srst) begin
            control <= `CT_RESET;
        end else if (wr && off == `TK_OFF_CONTROL && wp == 3'h0 && !wp_arm) begin
            control <= mem_wr_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wp <= 3'h0;
        end else if (wr && off == `TK_OFF_CONTROL && wp == 3'h0 && wp_arm) begin
            wp <= mem_wr_data[`CT_WP_LSB +: 3];
        end
    end

    // ======================================================
    // Status: enables and alarm flags
    always_ff @(posedge mclk) begin
        if (srst) begin
            ien_n <= `ST_IEN_RESET;
        end else if (wr && off == `TK_OFF_STATUS) begin
            ien_n <= mem_wr_data[`ST_IEN_LSB +: 3];
        end
    end

    assign hit[`ST_RTC_FLAG] = (rtc == rtc_alm);
    assign hit[`ST_ITV_FLAG] = (itv == itv_alm);
    assign hit[`ST_CYC_FLAG] = (cyc == cyc_alm);

    always_ff @(posedge mclk) begin
        if (srst) begin
            flags <= 3'h0;
        end else if (rd && off == `TK_OFF_STATUS) begin
            flags <= hit;
        end else begin
            flags <= flags | hit;
        end
    end

    // ======================================================
    // Seconds clock
    always_ff @(posedge mclk) begin
        if (srst) begin
            rtc <= '0;
        end else if (wr && !wp[0] && in_field(off, `TK_OFF_RTC, `TK_LEN5)) begin
            rtc <= set_byte(rtc, 3'(off - `TK_OFF_RTC), mem_wr_data);
        end else if (tick256) begin
            rtc <= rtc + 40'h00_0000_0001;
        end
    end

    // Interval timer
    always_ff @(posedge mclk) begin
        if (srst) begin
            itv <= '0;
        end else if (wr && !wp[1] && in_field(off, `TK_OFF_ITV, `TK_LEN5)) begin
            itv <= set_byte(itv, 3'(off - `TK_OFF_ITV), mem_wr_data);
        end else if (tick256 && itv_run) begin
            itv <= itv + 40'h00_0000_0001;
        end
    end

    // Cycle counter
    always_ff @(posedge mclk) begin
        if (srst) begin
            cyc <= '0;
        end else if (wr && !wp[2] && in_field(off, `TK_OFF_CYC, `TK_LEN4)) begin
            cyc <= 32'(set_byte({8'h00, cyc}, 3'(off - `TK_OFF_CYC), mem_wr_data));
        end else if (io_fall) begin
            cyc <= cyc + 32'h0000_0001;
        end
    end

    // ======================================================
    // Alarm registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            rtc_alm <= '1;
            itv_alm <= '1;
            cyc_alm <= '1;
        end else if (wr) begin
            if (!wp[0] && in_field(off, `TK_OFF_RTC_ALM, `TK_LEN5)) begin
                rtc_alm <= set_byte(rtc_alm, 3'(off - `TK_OFF_RTC_ALM), mem_wr_data);
            end
            if (!wp[1] && in_field(off, `TK_OFF_ITV_ALM, `TK_LEN5)) begin
                itv_alm <= set_byte(itv_alm, 3'(off - `TK_OFF_ITV_ALM), mem_wr_data);
            end
            if (!wp[2] && in_field(off, `TK_OFF_CYC_ALM, `TK_LEN4)) begin
                cyc_alm <= 32'(set_byte({8'h00, cyc_alm}, 3'(off - `TK_OFF_CYC_ALM),
                                        mem_wr_data));
            end
        end
    end

    // ======================================================
    // Snapshot holding registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            rtc_hold <= '0;
            itv_hold <= '0;
            cyc_hold <= '0;
        end else if (read_cmd_bit8) begin
            rtc_hold <= rtc;
            itv_hold <= itv;
            cyc_hold <= cyc;
        end
    end

    // ======================================================
    // Expiration
    always_comb begin
        next_expire = expire;
        if (expire == timekeeping_pkg::EXP_NONE && |(hit & wp)) begin
            next_expire = control[`CT_RO] ? timekeeping_pkg::EXP_READ_ONLY
                                          : timekeeping_pkg::EXP_ID_ONLY;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            expire <= timekeeping_pkg::EXP_NONE;
        end else begin
            expire <= next_expire;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            device_read_only <= 1'b0;
            device_id_only <= 1'b0;
        end else begin
            device_read_only <= (next_expire == timekeeping_pkg::EXP_READ_ONLY);
            device_id_only <= (next_expire == timekeeping_pkg::EXP_ID_ONLY);
        end
    end

    // ======================================================
    // Read mux
    always_comb begin
        next_rd_data = 8'h00;
        if (expire == timekeeping_pkg::EXP_ID_ONLY || !page_hit) begin
            next_rd_data = `UNMAPPED_READ;
        end else if (off == `TK_OFF_STATUS) begin
            next_rd_data = {2'b00, ien_n, flags};
        end else if (off == `TK_OFF_CONTROL) begin
            next_rd_data = {control[7:3], wp};
        end else if (in_field(off, `TK_OFF_RTC, `TK_LEN5)) begin
            next_rd_data = get_byte(rtc_hold, 3'(off - `TK_OFF_RTC));
        end else if (in_field(off, `TK_OFF_ITV, `TK_LEN5)) begin
            next_rd_data = get_byte(itv_hold, 3'(off - `TK_OFF_ITV));
        end else if (in_field(off, `TK_OFF_CYC, `TK_LEN4)) begin
            next_rd_data = get_byte({8'h00, cyc_hold}, 3'(off - `TK_OFF_CYC));
        end else if (in_field(off, `TK_OFF_RTC_ALM, `TK_LEN5)) begin
            next_rd_data = get_byte(rtc_alm, 3'(off - `TK_OFF_RTC_ALM));
        end else if (in_field(off, `TK_OFF_ITV_ALM, `TK_LEN5)) begin
            next_rd_data = get_byte(itv_alm, 3'(off - `TK_OFF_ITV_ALM));
        end else begin
            next_rd_data = get_byte({8'h00, cyc_alm}, 3'(off - `TK_OFF_CYC_ALM));
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mem_rd_data <= 8'h00;
            mem_rd_valid <= 1'b0;
        end else begin
            mem_rd_valid <= mem_rd_en;
            if (mem_rd_en) begin
                mem_rd_data <= next_rd_data;
            end
        end
    end

    // ======================================================
    // Interrupt and square wave pins
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_out <= 1'b0;
            irq_oe <= 1'b0;
            seconds_square_out <= 1'b0;
            seconds_square_oe <= 1'b0;
        end else begin
            irq_out <= 1'b0;
            irq_oe <= |(flags & ~ien_n);
            seconds_square_out <= 1'b0;
            seconds_square_oe <= ~rtc[7];
        end
    end

endmodule : timekeeping_counters_alarms

// file: verif/timekeeping_counters_alarms_chk.sv
/* Port checker for the timekeeping page.
   Assumes binding to the top module, one clock mclk. */
// ==========
// Checker
module timekeeping_counters_alarms_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Register port
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd_en,
    input wire logic [7:0] mem_rd_data,
    input wire logic mem_rd_valid,
    // Outputs
    input wire logic irq_out,
    input wire logic seconds_square_out,
    input wire logic seconds_square_oe,
    input wire logic device_read_only,
    input wire logic device_id_only
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    chk_rd_answer: assert property (mem_rd_en |=> mem_rd_valid)
        else $error("read not answered");
    chk_rd_quiet: assert property (!mem_rd_en |=> !mem_rd_valid)
        else $error("stray read valid");
    chk_off_page: assert property (mem_rd_en && mem_addr[15:5] != 11'h010
        |=> mem_rd_data == 8'hff) else $error("off page read not ff");
    chk_page_end: assert property (mem_rd_en && mem_addr[15:5] == 11'h010
        && mem_addr[4:0] > 5'h1d |=> mem_rd_data == 8'hff) else $error("past end not ff");
    chk_pins_low: assert property (!irq_out && !seconds_square_out)
        else $error("open drain value high");
    chk_ro_sticky: assert property (device_read_only |=> device_read_only)
        else $error("read only released");
    chk_id_sticky: assert property (device_id_only |=> device_id_only)
        else $error("id only released");
    chk_one_state: assert property (!(device_read_only && device_id_only))
        else $error("both expiry states");
    chk_id_reads: assert property (device_id_only && mem_rd_en |=> mem_rd_data == 8'hff)
        else $error("id only read not ff");
    chk_square_hold: assert property ($changed(seconds_square_oe)
        |=> $stable(seconds_square_oe)[*8]) else $error("square wave too fast");
endmodule : timekeeping_counters_alarms_chk

bind timekeeping_counters_alarms timekeeping_counters_alarms_chk i_chk (.mclk(mclk),
    .srst(srst), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_rd_data(mem_rd_data),
    .mem_rd_valid(mem_rd_valid), .irq_out(irq_out), .seconds_square_out(seconds_square_out),
    .seconds_square_oe(seconds_square_oe), .device_read_only(device_read_only),
    .device_id_only(device_id_only));

// file: verif/serial_master_model.sv
/* Serial bus master issuing memory-function commands as byte accesses.
   Assumes every task is entered at a falling edge of mclk. */
// ==========
// Master model
module serial_master_model (
    // Clock
    input wire logic mclk,
    // Register port
    output logic [15:0] mem_addr,
    output logic mem_wr_en,
    output logic [7:0] mem_wr_data,
    output logic wp_arm,
    output logic mem_rd_en,
    input wire logic [7:0] mem_rd_data,
    input wire logic mem_rd_valid,
    output logic read_cmd_bit8
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        mem_addr = 16'h0000;
        mem_wr_en = 1'b0;
        mem_wr_data = 8'h00;
        wp_arm = 1'b0;
        mem_rd_en = 1'b0;
        read_cmd_bit8 = 1'b0;
    end
    // Idle bus shows the inverted last value
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic arm);
        mem_addr = a;
        mem_wr_data = d;
        wp_arm = arm;
        mem_wr_en = 1'b1;
        @(negedge mclk);
        mem_wr_en = 1'b0;
        wp_arm = 1'b0;
        mem_addr = ~a;
        mem_wr_data = ~d;
        @(negedge mclk);
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        int n = 0;
        mem_addr = a;
        mem_rd_en = 1'b1;
        @(negedge mclk);
        mem_rd_en = 1'b0;
        mem_addr = ~a;
        while (mem_rd_valid !== 1'b1 && n < 3) begin
            @(negedge mclk);
            n++;
        end
        d = (mem_rd_valid === 1'b1) ? mem_rd_data : 8'hxx;
        @(negedge mclk);
    endtask : rd
    task automatic snap();
        read_cmd_bit8 = 1'b1;
        @(negedge mclk);
        read_cmd_bit8 = 1'b0;
        @(negedge mclk);
    endtask : snap
endmodule : serial_master_model

// file: verif/timekeeping_counters_alarms_test.sv
/* Self-checking bench for the timekeeping page.
   Assumes the master model drives the register port, bench drives io_line. */
`include "timekeeping_regs.svh"

// ==========
// Bench
module timekeeping_counters_alarms_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV = 4;
    localparam int TICK = DIV * 128;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic io_line = 1'b0;
    logic [15:0] mem_addr;
    logic mem_wr_en, wp_arm, mem_rd_en, mem_rd_valid, read_cmd_bit8;
    logic [7:0] mem_wr_data, mem_rd_data, b;
    logic irq_out, irq_oe, sq_out, sq_oe, ro, ido;
    logic [39:0] v, w;
    logic [31:0] seed = 32'h227f;
    int mismatches = 0;
    int samples_checked = 0;
    int cyc = 0;
    int t_on, al;
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;

    serial_master_model i_serial_master_model (.mclk(mclk), .mem_addr(mem_addr),
        .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data), .wp_arm(wp_arm),
        .mem_rd_en(mem_rd_en), .mem_rd_data(mem_rd_data), .mem_rd_valid(mem_rd_valid),
        .read_cmd_bit8(read_cmd_bit8));
    timekeeping_counters_alarms #(.OSC_DIV(DIV), .FILT_W(13)) i_timekeeping_counters_alarms (
        .mclk(mclk), .srst(srst), .mem_addr(mem_addr), .mem_wr_en(mem_wr_en),
        .mem_wr_data(mem_wr_data), .wp_arm(wp_arm), .mem_rd_en(mem_rd_en),
        .mem_rd_data(mem_rd_data), .mem_rd_valid(mem_rd_valid),
        .read_cmd_bit8(read_cmd_bit8), .io_line(io_line), .irq_out(irq_out),
        .irq_oe(irq_oe), .seconds_square_out(sq_out), .seconds_square_oe(sq_oe),
        .device_read_only(ro), .device_id_only(ido));

    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xorshift
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] s);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Counter values tolerate one tick of prescaler phase
    task automatic chk_rng(input string nm, input int e, input logic [39:0] s);
        int lo = (e > 0) ? e - 1 : 0;
        samples_checked++;
        if ((^s === 1'bx) || s < 40'(lo) || s > 40'(e + 1)) begin
            mismatches++;
            $display("BAD %s expected %0d seen %h", nm, e, s);
        end
    endtask : chk_rng
    task automatic wr_n(input logic [4:0] off, input logic [39:0] val, input int n);
        for (int i = 0; i < n; i++) begin
            i_serial_master_model.wr({11'h010, off + 5'(i)}, val[8*i +: 8], 1'b0);
        end
    endtask : wr_n
    task automatic rd_n(input logic [4:0] off, input int n, output logic [39:0] val);
        logic [7:0] d;
        val = '0;
        for (int i = 0; i < n; i++) begin
            i_serial_master_model.rd({11'h010, off + 5'(i)}, d);
            val[8*i +: 8] = d;
        end
    endtask : rd_n
    task automatic snap_rd(input logic [4:0] off, output logic [39:0] val);
        i_serial_master_model.snap();
        rd_n(off, (off == `TK_OFF_CYC) ? 4 : 5, val);
    endtask : snap_rd
    task automatic do_reset();
        srst = 1'b1;
        repeat (4) @(negedge mclk);
        srst = 1'b0;
    endtask : do_reset
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (100000) @(posedge mclk);
        mismatches++;
        summarize();
    end

    initial begin
        do_reset();
        rd_n(`TK_OFF_STATUS, 1, v);
        chk("status", 40'h38, v);
        rd_n(`TK_OFF_CONTROL, 1, v);
        chk("control", 40'h00, v);
        chk("square wave", 40'd1, sq_oe);
        i_serial_master_model.rd(16'h021e, b);
        chk("past end", 40'hff, b);
        i_serial_master_model.rd(16'h01ff, b);
        chk("data page", 40'hff, b);
        al = int'(xorshift() % 4) + 3;
        wr_n(`TK_OFF_RTC_ALM, 40'(al), 5);
        w = {8'h80 | 8'(xorshift()), xorshift()};
        wr_n(`TK_OFF_ITV_ALM, w, 5);
        rd_n(`TK_OFF_ITV_ALM, 5, v);
        chk("interval alarm", w, v);
        wr_n(`TK_OFF_CYC_ALM, 40'd1, 4);
        wr_n(`TK_OFF_STATUS, 40'h30, 1);
        repeat (1500) @(negedge mclk);
        snap_rd(`TK_OFF_RTC, v);
        chk("stopped clock", 40'd0, v);
        wr_n(`TK_OFF_CONTROL, 40'h10, 1);
        t_on = cyc;
        repeat (al * TICK + 700) @(negedge mclk);
        chk("irq", 40'd1, irq_oe);
        rd_n(`TK_OFF_STATUS, 1, v);
        chk("clock flag", 40'h31, v);
        repeat (3) @(negedge mclk);
        chk("irq cleared", 40'd0, irq_oe);
        snap_rd(`TK_OFF_RTC, v);
        chk_rng("clock", (cyc - t_on) / TICK, v);
        repeat (1100) @(negedge mclk);
        rd_n(`TK_OFF_RTC, 5, w);
        chk("frozen copy", v, w);
        wr_n(`TK_OFF_CONTROL, 40'h50, 1);
        snap_rd(`TK_OFF_ITV, v);
        repeat (1100) @(negedge mclk);
        snap_rd(`TK_OFF_ITV, w);
        chk("manual stop", v, w);
        wr_n(`TK_OFF_CONTROL, 40'h30, 1);
        repeat (1100) @(negedge mclk);
        snap_rd(`TK_OFF_ITV, w);
        chk("auto idle", v, w);
        io_line = 1'b1;
        repeat (600 + 5 * TICK) @(negedge mclk);
        snap_rd(`TK_OFF_ITV, w);
        chk_rng("auto run", int'(v) + 5, w);
        io_line = 1'b0;
        repeat (700) @(negedge mclk);
        snap_rd(`TK_OFF_CYC, v);
        chk("cycle count", 40'd1, v);
        rd_n(`TK_OFF_STATUS, 1, v);
        chk("cycle flag", 40'h34, v);
        chk("irq masked", 40'd0, irq_oe);
        io_line = 1'b1;
        repeat (200) @(negedge mclk);
        io_line = 1'b0;
        repeat (700) @(negedge mclk);
        snap_rd(`TK_OFF_CYC, v);
        chk("short pulse", 40'd1, v);
        wr_n(`TK_OFF_CONTROL, 40'hb0, 1);
        io_line = 1'b1;
        repeat (1000) @(negedge mclk);
        io_line = 1'b0;
        repeat (1000) @(negedge mclk);
        snap_rd(`TK_OFF_CYC, v);
        chk("long delay", 40'd1, v);
        do_reset();
        wr_n(`TK_OFF_RTC_ALM, 40'd4, 5);
        wr_n(`TK_OFF_CONTROL, 40'h18, 1);
        i_serial_master_model.wr(16'h0201, 8'h01, 1'b1);
        wr_n(`TK_OFF_CONTROL, 40'h00, 1);
        rd_n(`TK_OFF_CONTROL, 1, v);
        chk("locked control", 40'h19, v);
        wr_n(`TK_OFF_RTC_ALM, 40'h55, 1);
        rd_n(`TK_OFF_RTC_ALM, 1, v);
        chk("locked alarm", 40'h04, v);
        repeat (4 * TICK + 700) @(negedge mclk);
        chk("read only", 40'h2, {ro, ido});
        rd_n(`TK_OFF_CONTROL, 1, v);
        chk("read only access", 40'h19, v);
        do_reset();
        wr_n(`TK_OFF_RTC_ALM, 40'd4, 5);
        wr_n(`TK_OFF_CONTROL, 40'h10, 1);
        i_serial_master_model.wr(16'h0201, 8'h01, 1'b1);
        repeat (4 * TICK + 700) @(negedge mclk);
        chk("id only", 40'h1, {ro, ido});
        rd_n(`TK_OFF_STATUS, 1, v);
        chk("id only access", 40'hff, v);
        summarize();
    end
endmodule : timekeeping_counters_alarms_test
